/* hw/biod_pkg.sv */
// Constants, types and register map of the bus instruction output decoder.
// Assumes one 10 MHz clock and a Wishbone classic register port.
//
// Notes on behaviour
// - Reset character while listening: standby, internal sense, lock off, 100 uV.
// - Listen indication high only when correctly addressed; instructions need it.
// - Operate line low after N, high after S, held until next one.
// - Phase-lock line low after F1, high after F0.
// - Sense line low after X1 (external), high after X0 (internal).
// - Voltage on 24 active-low lines, six digits by four weights, rest high.
// - All-ones value drives only each weight-one line low.
// - All-twos value drives only each weight-two line low.
// - All-fours value drives only each weight-four line low.
// - All-eights value drives only each weight-eight line low.
package biod_pkg;

    // Wishbone byte addresses
    localparam logic [3:0] ADR_CTRL   = 4'h0;
    localparam logic [3:0] ADR_STATUS = 4'h4;
    localparam logic [3:0] ADR_VOLT   = 4'h8;

    // Field positions
    localparam int CTRL_ADDR_LSB = 0;
    localparam int STAT_MLA_BIT  = 0;
    localparam int STAT_OPER_BIT = 1;
    localparam int STAT_LOCK_BIT = 2;
    localparam int STAT_SENS_BIT = 3;

    // Values after reset
    localparam logic [4:0]  RST_LISTEN_ADDR = 5'h00;
    localparam logic [23:0] RST_VOLT_BCD    = 24'h10_0000;

    // Bus address bytes
    localparam logic [1:0]  LISTEN_GROUP = 2'h1;
    localparam logic [7:0]  CH_UNLISTEN  = 8'h3F;

    // Instruction characters
    localparam logic [7:0] CH_STAR  = 8'h2A;
    localparam logic [7:0] CH_OPER  = 8'h4E;
    localparam logic [7:0] CH_STBY  = 8'h53;
    localparam logic [7:0] CH_LOCK  = 8'h46;
    localparam logic [7:0] CH_SENSE = 8'h58;
    localparam logic [7:0] CH_ZERO  = 8'h30;
    localparam logic [7:0] CH_ONE   = 8'h31;
    localparam logic [7:0] CH_NINE  = 8'h39;
    localparam logic [7:0] CH_EXP   = 8'h45;
    localparam logic [7:0] CH_VOLT  = 8'h56;
    localparam logic [7:0] CH_HERTZ = 8'h48;

    // Control lines, all active low
    typedef struct packed {
        logic operate_n;
        logic phase_n;
        logic sense_n;
    } biod_ctl_t;

    localparam biod_ctl_t RST_CTL = '{operate_n: 1'b1, phase_n: 1'b1, sense_n: 1'b1};

    // Two-character instruction tracking
    typedef enum logic [1:0] {
        ST_IDLE   = 2'b00,
        ST_PAIR_F = 2'b01,
        ST_PAIR_X = 2'b11
    } biod_state_t;

endpackage

/* hw/biod_digit_lines.sv */
// Six-digit BCD to 24 active-low weighted lines.
// Assumes digits hold 0 to 9; weight order per digit is 1, 2, 4, 8 from the low bit.
`timescale 1ns/1ns
`default_nettype none
module biod_digit_lines (
    input  wire logic [23:0] bcd,
    output logic      [23:0] lines_n
);
    import biod_pkg::*;

    // One nibble per digit; a set weight pulls its line low
    genvar d;
    generate
        for (d = 0; d < 6; d++) begin : g_digit
            assign lines_n[4*d +: 4] = ~bcd[4*d +: 4];
        end
    endgenerate
endmodule
`default_nettype wire

/* hw/biod_top.sv */
// Listener-side instruction interpreter with static control and voltage lines.
// Assumes bus bytes arrive as one-cycle strobes synchronous to MCLK after handshake.
`timescale 1ns/1ns
`default_nettype none
module biod_top (
    input  wire logic        MCLK,
    input  wire logic        RST,
    input  wire logic        WB_CYC_I,
    input  wire logic        WB_STB_I,
    input  wire logic        WB_WE_I,
    input  wire logic [3:0]  WB_ADR_I,
    input  wire logic [3:0]  WB_SEL_I,
    input  wire logic [31:0] WB_DAT_I,
    output logic      [31:0] WB_DAT_O,
    output logic             WB_ACK_O,
    input  wire logic [7:0]  GPIB_DIO,
    input  wire logic        GPIB_ATN_N,
    input  wire logic        GPIB_BYTE_STB,
    output logic             MLA,
    output logic             OPERATE_N,
    output logic             PHASE_LOCK_N,
    output logic             SENSE_SEL_N,
    output logic      [23:0] VOLT_N
);
    import biod_pkg::*;

    logic [4:0]        addr_ff,     nxt_addr;
    logic              ack_ff,      nxt_ack;
    logic [31:0]       rdat_ff,     nxt_rdat;
    logic              mla_ff,      nxt_mla;
    biod_ctl_t         ctl_ff,      nxt_ctl;
    biod_state_t       state_ff,    nxt_state;
    logic [23:0]       buf_ff,      nxt_buf;
    logic              exp_ff,      nxt_exp;
    logic [23:0]       volt_ff,     nxt_volt;
    logic [23:0]       lines_ff;
    logic [23:0]       lines_n;
    logic              cmd_byte;
    logic              data_byte;
    logic              is_digit;
    logic              volt_load;

    // Byte qualifiers
    assign cmd_byte  = GPIB_BYTE_STB && !GPIB_ATN_N;
    assign data_byte = GPIB_BYTE_STB && GPIB_ATN_N && mla_ff;
    assign is_digit  = (GPIB_DIO >= CH_ZERO) && (GPIB_DIO <= CH_NINE);

    // Wishbone slave: ack one cycle after the request, write at the acked edge
    always_comb begin
        nxt_ack  = WB_CYC_I && WB_STB_I && !ack_ff;
        nxt_addr = addr_ff;
        nxt_rdat = 32'h0000_0000;
        if (WB_CYC_I && WB_STB_I && WB_WE_I && ack_ff && WB_ADR_I == ADR_CTRL && WB_SEL_I[0]) begin
            nxt_addr = WB_DAT_I[CTRL_ADDR_LSB +: 5];
        end
        case (WB_ADR_I)
            ADR_CTRL: begin
                nxt_rdat[CTRL_ADDR_LSB +: 5] = addr_ff;
            end
            ADR_STATUS: begin
                nxt_rdat[STAT_MLA_BIT]  = mla_ff;
                nxt_rdat[STAT_OPER_BIT] = ctl_ff.operate_n;
                nxt_rdat[STAT_LOCK_BIT] = ctl_ff.phase_n;
                nxt_rdat[STAT_SENS_BIT] = ctl_ff.sense_n;
            end
            ADR_VOLT: begin
                nxt_rdat[23:0] = volt_ff;
            end
            default: begin
                nxt_rdat = 32'h0000_0000; // Unmapped reads zero, writes dropped
            end
        endcase
    end

    // Listen addressing: only commands under ATN move the listen state
    always_comb begin
        nxt_mla = mla_ff;
        if (cmd_byte) begin
            if (GPIB_DIO == CH_UNLISTEN) begin
                nxt_mla = 1'b0;
            end else if (GPIB_DIO[6:5] == LISTEN_GROUP && GPIB_DIO[4:0] == addr_ff) begin
                nxt_mla = 1'b1;
            end
        end
    end

    // Instruction interpreter; digits wait in a buffer so lines never show halves
    always_comb begin
        nxt_ctl   = ctl_ff;
        nxt_state = state_ff;
        nxt_buf   = buf_ff;
        nxt_exp   = exp_ff;
        nxt_volt  = volt_ff;
        volt_load = 1'b0;
        if (data_byte) begin
            nxt_state = ST_IDLE;
            case (state_ff)
                ST_PAIR_F: begin
                    if (GPIB_DIO == CH_ONE) nxt_ctl.phase_n = 1'b0;
                    if (GPIB_DIO == CH_ZERO) nxt_ctl.phase_n = 1'b1;
                end
                ST_PAIR_X: begin
                    if (GPIB_DIO == CH_ONE) nxt_ctl.sense_n = 1'b0;
                    if (GPIB_DIO == CH_ZERO) nxt_ctl.sense_n = 1'b1;
                end
                default: begin
                    if (GPIB_DIO == CH_STAR) begin
                        nxt_ctl   = RST_CTL;
                        nxt_volt  = RST_VOLT_BCD;
                        volt_load = 1'b1;
                        nxt_buf   = 24'h00_0000;
                        nxt_exp   = 1'b0;
                    end else if (GPIB_DIO == CH_OPER) begin
                        nxt_ctl.operate_n = 1'b0;
                    end else if (GPIB_DIO == CH_STBY) begin
                        nxt_ctl.operate_n = 1'b1;
                    end else if (GPIB_DIO == CH_LOCK) begin
                        nxt_state = ST_PAIR_F;
                    end else if (GPIB_DIO == CH_SENSE) begin
                        nxt_state = ST_PAIR_X;
                    end else if (is_digit && !exp_ff) begin
                        nxt_buf = {buf_ff[19:0], GPIB_DIO[3:0]};
                    end else if (GPIB_DIO == CH_EXP) begin
                        nxt_exp = 1'b1; // Digits after the exponent are not buffered
                    end else if (GPIB_DIO == CH_VOLT) begin
                        nxt_volt  = buf_ff;
                        volt_load = 1'b1;
                        nxt_buf   = 24'h00_0000;
                        nxt_exp   = 1'b0;
                    end else if (GPIB_DIO == CH_HERTZ) begin
                        nxt_buf = 24'h00_0000; // Frequency handled elsewhere
                        nxt_exp = 1'b0;
                    end
                end
            endcase
        end
    end

    // Line decoder feeds the output flops from the next value, saving a cycle
    biod_digit_lines u_lines (
        .bcd     (nxt_volt),
        .lines_n (lines_n)
    );

    // State registers
    always_ff @(posedge MCLK) begin
        if (RST) begin
            addr_ff  <= RST_LISTEN_ADDR;
            ack_ff   <= 1'b0;
            rdat_ff  <= 32'h0000_0000;
            mla_ff   <= 1'b0;
            ctl_ff   <= RST_CTL;
            state_ff <= ST_IDLE;
            buf_ff   <= 24'h00_0000;
            exp_ff   <= 1'b0;
            volt_ff  <= RST_VOLT_BCD;
            lines_ff <= ~RST_VOLT_BCD;
        end else begin
            addr_ff  <= nxt_addr;
            ack_ff   <= nxt_ack;
            rdat_ff  <= nxt_rdat;
            mla_ff   <= nxt_mla;
            ctl_ff   <= nxt_ctl;
            state_ff <= nxt_state;
            buf_ff   <= nxt_buf;
            exp_ff   <= nxt_exp;
            volt_ff  <= nxt_volt;
            lines_ff <= lines_n;
        end
    end

    // Outputs straight from flops
    assign WB_ACK_O     = ack_ff;
    assign WB_DAT_O     = rdat_ff;
    assign MLA          = mla_ff;
    assign OPERATE_N    = ctl_ff.operate_n;
    assign PHASE_LOCK_N = ctl_ff.phase_n;
    assign SENSE_SEL_N  = ctl_ff.sense_n;
    assign VOLT_N       = lines_ff;

    // Checks
    sequence s_data(logic [7:0] ch);
        data_byte && GPIB_DIO == ch;
    endsequence

    sequence s_pair(biod_state_t st, logic [7:0] ch);
        state_ff == st ##0 s_data(ch);
    endsequence

    a_reset_char_state: assert property (@(posedge MCLK) disable iff (RST)
        s_pair(ST_IDLE, CH_STAR) |=> OPERATE_N && SENSE_SEL_N
            && PHASE_LOCK_N && VOLT_N == ~RST_VOLT_BCD)
        else $error("reset character did not restore defaults");

    a_listen_gate: assert property (@(posedge MCLK) disable iff (RST)
        !$stable({OPERATE_N, PHASE_LOCK_N, SENSE_SEL_N}) |-> $past(mla_ff))
        else $error("control line moved while not listening");

    a_operate_on: assert property (@(posedge MCLK) disable iff (RST)
        s_pair(ST_IDLE, CH_OPER) |=> !OPERATE_N)
        else $error("operate line not low after operate character");

    a_operate_hold: assert property (@(posedge MCLK) disable iff (RST)
        !$past(data_byte) |-> $stable(OPERATE_N))
        else $error("operate line changed without a character");

    a_lock_pair: assert property (@(posedge MCLK) disable iff (RST)
        s_pair(ST_PAIR_F, CH_ONE) |=> !PHASE_LOCK_N)
        else $error("phase lock line not low after enable pair");

    a_sense_pair: assert property (@(posedge MCLK) disable iff (RST)
        s_pair(ST_PAIR_X, CH_ZERO) |=> SENSE_SEL_N)
        else $error("sense line not high after internal pair");

    a_volt_load: assert property (@(posedge MCLK) disable iff (RST)
        s_pair(ST_IDLE, CH_VOLT) |=> VOLT_N == ~$past(buf_ff))
        else $error("voltage lines do not match buffered digits");

    a_volt_ones: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == ST_IDLE && buf_ff == 24'h11_1111 ##0 s_data(CH_VOLT)
            |=> VOLT_N == 24'hEE_EEEE)
        else $error("all-ones value drove wrong lines");

    a_volt_twos: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == ST_IDLE && buf_ff == 24'h22_2222 ##0 s_data(CH_VOLT)
            |=> VOLT_N == 24'hDD_DDDD)
        else $error("all-twos value drove wrong lines");

    a_volt_fours: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == ST_IDLE && buf_ff == 24'h44_4444 ##0 s_data(CH_VOLT)
            |=> VOLT_N == 24'hBB_BBBB)
        else $error("all-fours value drove wrong lines");

    a_volt_eights: assert property (@(posedge MCLK) disable iff (RST)
        state_ff == ST_IDLE && buf_ff == 24'h88_8888 ##0 s_data(CH_VOLT)
            |=> VOLT_N == 24'h77_7777)
        else $error("all-eights value drove wrong lines");

    a_volt_atomic: assert property (@(posedge MCLK) disable iff (RST)
        !$past(volt_load) |-> $stable(VOLT_N))
        else $error("voltage lines changed before unit letter");
endmodule
`default_nettype wire

/* tb/biod_ctlr_model.sv */
// Bus controller model: sends addressing bytes and ASCII instructions.
// Assumes the external handshake is reduced to a one-cycle byte strobe.
`timescale 1ns/1ns
`default_nettype none
module biod_ctlr_model (
    input  wire logic       mclk,
    output logic      [7:0] dio,
    output logic            atn_n,
    output logic            byte_stb
);
    // Idle bus: no strobe, attention released
    initial begin
        dio      = 8'hFF;
        atn_n    = 1'b1;
        byte_stb = 1'b0;
    end

    // One byte per call; attention low marks an addressing command
    task automatic send_byte(logic atn, logic [7:0] b);
        @(posedge mclk);
        dio      <= b;
        atn_n    <= atn;
        byte_stb <= 1'b1;
        @(posedge mclk);
        byte_stb <= 1'b0;
        atn_n    <= 1'b1;
        dio      <= ~b; // Released lines must not keep the last value
    endtask

    // Instruction string, with optional pause to act as a slow controller
    task automatic send_str(string s, int gap);
        for (int i = 0; i < s.len(); i++) begin
            send_byte(1'b1, s[i]);
            repeat (gap) @(posedge mclk);
        end
    endtask
endmodule
`default_nettype wire

/* tb/tb_top.sv */
// Testbench: register tasks on Wishbone plus instruction strings from the controller.
// Assumes the design answers a request one cycle after it is first sampled.
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    import biod_pkg::*;
    logic        mclk;
    logic        rst;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [3:0]  adr;
    logic [3:0]  sel;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic        ack;
    logic [7:0]  dio;
    logic        atn_n;
    logic        bstb;
    logic        mla;
    logic        oper_n;
    logic        lock_n;
    logic        sense_n;
    logic [23:0] volt_n;
    logic [31:0] rd;
    logic [23:0] bcd;
    logic [23:0] prev;
    int          errors;
    int          checks;
    string       cmds [6] = '{"N", "S", "F1", "F0", "X1", "X0"};
    logic [3:0]  ctls [6] = '{4'hD, 4'hF, 4'hB, 4'hF, 4'h7, 4'hF};

    biod_top i_biod_top (.MCLK(mclk), .RST(rst), .WB_CYC_I(cyc), .WB_STB_I(stb),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(rdat),
        .WB_ACK_O(ack), .GPIB_DIO(dio), .GPIB_ATN_N(atn_n), .GPIB_BYTE_STB(bstb),
        .MLA(mla), .OPERATE_N(oper_n), .PHASE_LOCK_N(lock_n), .SENSE_SEL_N(sense_n),
        .VOLT_N(volt_n));
    biod_ctlr_model i_biod_ctlr_model (.mclk(mclk), .dio(dio), .atn_n(atn_n),
        .byte_stb(bstb));

    // 10 MHz clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    task automatic chk(string what, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // Classic single cycle; only the watchdog ends a wait on a dead slave
    task automatic wb(logic w, logic [3:0] a, logic [31:0] d, output logic [31:0] q);
        int n;
        @(posedge mclk);
        cyc  <= 1'b1;
        stb  <= 1'b1;
        we   <= w;
        adr  <= a;
        wdat <= d;
        sel  <= 4'h1;
        n = 0;
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        chk("bus ack delay", n, 32'h0000_0002);
    endtask

    // Pins and status register against {sense, lock, operate, listen}
    task automatic outs(logic [3:0] ctl, logic [23:0] v);
        #1;
        chk("ctl lines", {28'h0, sense_n, lock_n, oper_n, mla}, {28'h0, ctl});
        chk("volt lines", {8'h0, volt_n}, {8'h0, v});
        wb(1'b0, ADR_STATUS, 32'h0, rd);
        chk("status reg", rd, {28'h0, ctl});
    endtask

    task automatic finish_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    // Watchdog well beyond the few hundred cycles the tests need
    initial begin
        repeat (5000) @(posedge mclk);
        errors++;
        finish_test();
    end

    initial begin
        {rst, cyc, stb, we, adr, sel, wdat} = {1'b1, 43'h0};
        errors = 0;
        checks = 0;
        repeat (16) @(posedge mclk);
        rst <= 1'b0;
        outs(4'hE, 24'hEF_FFFF);
        wb(1'b0, ADR_VOLT, 32'h0, rd);
        chk("volt reg", rd, 32'h0010_0000);
        wb(1'b0, 4'hC, 32'h0, rd);
        chk("unmapped", rd, 32'h0);
        wb(1'b1, ADR_CTRL, 32'h0000_000A, rd);
        wb(1'b0, ADR_CTRL, 32'h0, rd);
        chk("listen addr", rd, 32'h0000_000A);
        $display("test reset_regs done");
        // Data before addressing and a foreign address are both ignored
        i_biod_ctlr_model.send_str("N", 0);
        outs(4'hE, 24'hEF_FFFF);
        i_biod_ctlr_model.send_byte(1'b0, 8'h25);
        outs(4'hE, 24'hEF_FFFF);
        i_biod_ctlr_model.send_byte(1'b0, 8'h2A);
        outs(4'hF, 24'hEF_FFFF);
        $display("test addressing done");
        for (int i = 0; i < 6; i++) begin
            i_biod_ctlr_model.send_str(cmds[i], (i % 2) * 3);
            outs(ctls[i], 24'hEF_FFFF);
        end
        $display("test control_lines done");
        // Digits must not reach the pins before the unit letter
        prev = 24'hEF_FFFF;
        for (int d = 1; d <= 8; d = d * 2) begin
            bcd = {6{d[3:0]}};
            i_biod_ctlr_model.send_str($sformatf("%0d%0d%0d.%0d%0d%0dE-6", d, d, d, d, d, d), 0);
            outs(4'hF, prev);
            i_biod_ctlr_model.send_str("V", 0);
            outs(4'hF, ~bcd);
            wb(1'b0, ADR_VOLT, 32'h0, rd);
            chk("volt reg", rd, {8'h0, bcd});
            prev = ~bcd;
        end
        $display("test voltage done");
        i_biod_ctlr_model.send_str("NF1X1", 1);
        outs(4'h1, prev);
        i_biod_ctlr_model.send_str("*", 0);
        outs(4'hF, 24'hEF_FFFF);
        $display("test reset_char done");
        i_biod_ctlr_model.send_byte(1'b0, CH_UNLISTEN);
        i_biod_ctlr_model.send_str("N", 0);
        outs(4'hE, 24'hEF_FFFF);
        $display("test unlisten done");
        finish_test();
    end
endmodule
`default_nettype wire
